// file: design/voltage_monitor_pkg.sv
// Constants shared by the voltage monitor register bank
package voltage_monitor_pkg;
  localparam int NUM_CH = 11;
  localparam int NUM_BANKS = 10;
  localparam int ADDR_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_STS_LO = 4'h0;
  localparam logic [3:0] IDX_STS_HI = 4'h1;
  localparam logic [3:0] IDX_SMI_LO = 4'h2;
  localparam logic [3:0] IDX_SMI_HI = 4'h3;
  localparam logic [3:0] IDX_IRQ_LO = 4'h4;
  localparam logic [3:0] IDX_IRQ_HI = 4'h5;
  localparam logic [3:0] IDX_VID = 4'h6;
  localparam logic [3:0] IDX_CNVR = 4'h7;
  localparam logic [3:0] IDX_MCFG = 4'h8;
  localparam logic [3:0] IDX_BANK = 4'h9;
  localparam logic [3:0] IDX_CFGST = 4'ha;
  localparam logic [3:0] IDX_READ = 4'hb;
  localparam logic [3:0] IDX_HLIM = 4'hc;
  localparam logic [3:0] IDX_LLIM = 4'hd;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_HLIM = 8'hff;
  localparam logic [7:0] RST_LLIM = 8'h00;
  // Channel config/status fields
  localparam int CFG_EN = 0;
  localparam int CFG_ALM = 1;
  localparam int CFG_HI = 2;
  localparam int CFG_LO = 3;
  // Monitor config fields
  localparam int MCFG_STBY = 0;
  localparam int MCFG_IREF = 1;
  // Voltage ident fields and register widths
  localparam int VID_SEL_LSB = 6;
  localparam int VID_W = 5;
  localparam int CNVR_W = 6;
  localparam int STS_HI_W = 3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: design/voltage_monitor_banked_regs.sv
// Banked register file and event reporting of the voltage monitor
module voltage_monitor_banked_regs (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [10:0] hi_exceed_i,
  input wire logic [10:0] lo_exceed_i,
  input wire logic [87:0] readout_i,
  input wire logic [10:0] readout_valid_i,
  input wire logic [4:0] vid_cpu0_i,
  input wire logic [4:0] vid_cpu1_i,
  input wire logic tms_int_ref_i,
  output logic mgmt_irq_o,
  output logic host_irq_o,
  output logic alarm_o,
  output logic use_internal_ref_o,
  output logic standby_o,
  output logic [5:0] conv_rate_o,
  output logic [10:0] chan_enable_o,
  output logic [87:0] high_limit_o,
  output logic [87:0] low_limit_o
);
  localparam int NC = voltage_monitor_pkg::NUM_CH;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic aw_full_q, w_full_q, bvalid_q, awready_q, wready_q;
  logic arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] rdata_q;
  // Decode results feed the slave registers ahead of the decode section
  logic wr_map, rd_map;
  logic [7:0] rd_val;

  wire aw_take = s_axi_awvalid_i & awready_q;
  wire w_take = s_axi_wvalid_i & wready_q;
  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = (aw_full_q | aw_take) & ~do_wr;
  wire w_full_d = (w_full_q | w_take) & ~do_wr;
  wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready_i);
  wire ar_take = s_axi_arvalid_i & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready_i);

  // Write side holds one address and one data until both are present
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bresp_q <= voltage_monitor_pkg::RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      bvalid_q <= bvalid_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      if (do_wr) begin
        bresp_q <= wr_map ? voltage_monitor_pkg::RESP_OKAY : voltage_monitor_pkg::RESP_DECERR;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else begin
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata_i[7:0];
        wstrb_q <= s_axi_wstrb_i[0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= voltage_monitor_pkg::RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_val;
        rresp_q <= rd_map ? voltage_monitor_pkg::RESP_OKAY : voltage_monitor_pkg::RESP_DECERR;
      end
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  // Registers are eight bits wide; upper lanes read zero
  assign s_axi_rdata_o = {24'h000000, rdata_q};

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [7:0] bank_q;
  assign wr_map = (awaddr_q[7:6] == 2'h0);
  wire [3:0] wr_idx = awaddr_q[5:2];
  wire we = do_wr & wr_map & wstrb_q;
  wire bank_ok = (bank_q < 8'(voltage_monitor_pkg::NUM_BANKS));
  assign rd_map = (s_axi_araddr_i[7:6] == 2'h0);
  wire [3:0] rd_idx = s_axi_araddr_i[5:2];
  wire [3:0] sel_ch = bank_q[3:0];
  wire we_smi_lo = we & (wr_idx == voltage_monitor_pkg::IDX_SMI_LO);
  wire we_smi_hi = we & (wr_idx == voltage_monitor_pkg::IDX_SMI_HI);
  wire we_irq_lo = we & (wr_idx == voltage_monitor_pkg::IDX_IRQ_LO);
  wire we_irq_hi = we & (wr_idx == voltage_monitor_pkg::IDX_IRQ_HI);
  wire we_vid = we & (wr_idx == voltage_monitor_pkg::IDX_VID);
  wire we_cnvr = we & (wr_idx == voltage_monitor_pkg::IDX_CNVR);
  wire we_mcfg = we & (wr_idx == voltage_monitor_pkg::IDX_MCFG);
  wire we_bank = we & (wr_idx == voltage_monitor_pkg::IDX_BANK);

  // ----------------------------------------------------------------
  // Common registers
  // ----------------------------------------------------------------
  logic [7:0] smi_lo_q, irq_lo_q, mcfg_q;
  logic [2:0] smi_hi_q, irq_hi_q;
  logic [1:0] vid_sel_q;
  logic [5:0] cnvr_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      smi_lo_q <= voltage_monitor_pkg::RST_BYTE;
      smi_hi_q <= voltage_monitor_pkg::RST_BYTE[2:0];
      irq_lo_q <= voltage_monitor_pkg::RST_BYTE;
      irq_hi_q <= voltage_monitor_pkg::RST_BYTE[2:0];
      vid_sel_q <= voltage_monitor_pkg::RST_BYTE[1:0];
      cnvr_q <= voltage_monitor_pkg::RST_BYTE[5:0];
      mcfg_q <= voltage_monitor_pkg::RST_BYTE;
      bank_q <= voltage_monitor_pkg::RST_BYTE;
    end else begin
      if (we_smi_lo) smi_lo_q <= wdata_q;
      if (we_smi_hi) smi_hi_q <= wdata_q[2:0];
      if (we_irq_lo) irq_lo_q <= wdata_q;
      if (we_irq_hi) irq_hi_q <= wdata_q[2:0];
      // Only the select field is stored; the value bits come from pins
      if (we_vid) vid_sel_q <= wdata_q[7:6];
      if (we_cnvr) cnvr_q <= wdata_q[5:0];
      if (we_mcfg) mcfg_q <= {6'h00, wdata_q[1:0]};
      if (we_bank) bank_q <= wdata_q;
    end
  end

  // ----------------------------------------------------------------
  // Voltage ident pins: three-stage sync, accept when last two agree
  // ----------------------------------------------------------------
  logic [9:0] vid_s1_q, vid_s2_q, vid_s3_q, vid_q;
  wire [9:0] vid_diff = vid_s2_q ^ vid_s3_q;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      vid_s1_q <= 10'h000;
      vid_s2_q <= 10'h000;
      vid_s3_q <= 10'h000;
      vid_q <= 10'h000;
    end else begin
      vid_s1_q <= {vid_cpu1_i, vid_cpu0_i};
      vid_s2_q <= vid_s1_q;
      vid_s3_q <= vid_s2_q;
      vid_q <= (vid_s3_q & ~vid_diff) | (vid_q & vid_diff);
    end
  end
  wire [4:0] vid_val = (vid_sel_q == 2'h0) ? vid_q[4:0] : (vid_sel_q == 2'h1) ? vid_q[9:5] : 5'h00;

  // ----------------------------------------------------------------
  // Channel banks; channel 10 has flags but no reachable bank
  // ----------------------------------------------------------------
  logic [NC-1:0] en_q, alm_q, hi_q, lo_q;
  logic [7:0] rdv_q [NC];
  logic [7:0] hlim_q [NC];
  logic [7:0] llim_q [NC];
  wire [NC-1:0] ch_we;
  wire [NC-1:0] evt_status;
  wire [NC-1:0] hi_clr, lo_clr;

  for (genvar ch = 0; ch < NC; ch++) begin : g_ch
    assign ch_we[ch] = we & bank_ok & (bank_q == 8'(ch));
    wire cfg_we = ch_we[ch] & (wr_idx == voltage_monitor_pkg::IDX_CFGST);
    assign hi_clr[ch] = cfg_we & wdata_q[voltage_monitor_pkg::CFG_HI];
    assign lo_clr[ch] = cfg_we & wdata_q[voltage_monitor_pkg::CFG_LO];
    // Event status is the OR of the sticky channel flags
    assign evt_status[ch] = hi_q[ch] | lo_q[ch];
    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        en_q[ch] <= 1'b0;
        alm_q[ch] <= 1'b0;
        hi_q[ch] <= 1'b0;
        lo_q[ch] <= 1'b0;
        rdv_q[ch] <= voltage_monitor_pkg::RST_BYTE;
        hlim_q[ch] <= voltage_monitor_pkg::RST_HLIM;
        llim_q[ch] <= voltage_monitor_pkg::RST_LLIM;
      end else begin
        if (cfg_we) begin
          en_q[ch] <= wdata_q[voltage_monitor_pkg::CFG_EN];
          alm_q[ch] <= wdata_q[voltage_monitor_pkg::CFG_ALM];
        end
        // A new event wins over a clear in the same cycle
        hi_q[ch] <= hi_exceed_i[ch] | (hi_q[ch] & ~hi_clr[ch]);
        lo_q[ch] <= lo_exceed_i[ch] | (lo_q[ch] & ~lo_clr[ch]);
        if (readout_valid_i[ch]) rdv_q[ch] <= readout_i[ch*8 +: 8];
        if (ch_we[ch] && wr_idx == voltage_monitor_pkg::IDX_HLIM) hlim_q[ch] <= wdata_q;
        if (ch_we[ch] && wr_idx == voltage_monitor_pkg::IDX_LLIM) llim_q[ch] <= wdata_q;
      end
    end
    assign high_limit_o[ch*8 +: 8] = hlim_q[ch];
    assign low_limit_o[ch*8 +: 8] = llim_q[ch];
  end

  // ----------------------------------------------------------------
  // Status and interrupt outputs
  // ----------------------------------------------------------------
  // Bits 6-0 inputs, 7 standby, 8 main, 9 battery, 10 analog supply
  wire [7:0] sts_lo = evt_status[7:0];
  wire [7:0] sts_hi = {5'h00, evt_status[10:8]};
  wire [NC-1:0] smi_en = {smi_hi_q, smi_lo_q};
  wire [NC-1:0] irq_en = {irq_hi_q, irq_lo_q};
  wire iref_any = mcfg_q[voltage_monitor_pkg::MCFG_IREF] | tms_int_ref_i;
  logic mgmt_q, host_q, alarm_q, iref_q;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mgmt_q <= 1'b0;
      host_q <= 1'b0;
      alarm_q <= 1'b0;
      iref_q <= 1'b0;
    end else begin
      mgmt_q <= |(evt_status & smi_en);
      host_q <= |(evt_status & irq_en);
      alarm_q <= |(evt_status & alm_q);
      iref_q <= iref_any;
    end
  end

  assign mgmt_irq_o = mgmt_q;
  assign host_irq_o = host_q;
  assign alarm_o = alarm_q;
  assign use_internal_ref_o = iref_q;
  assign standby_o = mcfg_q[voltage_monitor_pkg::MCFG_STBY];
  assign conv_rate_o = cnvr_q;
  assign chan_enable_o = en_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] cfg_rd = {4'h0, lo_q[sel_ch], hi_q[sel_ch], alm_q[sel_ch], en_q[sel_ch]};
  wire [7:0] bank_rd = (rd_idx == voltage_monitor_pkg::IDX_CFGST) ? cfg_rd :
                       (rd_idx == voltage_monitor_pkg::IDX_READ) ? rdv_q[sel_ch] :
                       (rd_idx == voltage_monitor_pkg::IDX_HLIM) ? hlim_q[sel_ch] :
                       (rd_idx == voltage_monitor_pkg::IDX_LLIM) ? llim_q[sel_ch] : 8'h00;
  assign rd_val = !rd_map ? 8'h00 :
                      (rd_idx == voltage_monitor_pkg::IDX_STS_LO) ? sts_lo :
                      (rd_idx == voltage_monitor_pkg::IDX_STS_HI) ? sts_hi :
                      (rd_idx == voltage_monitor_pkg::IDX_SMI_LO) ? smi_lo_q :
                      (rd_idx == voltage_monitor_pkg::IDX_SMI_HI) ? {5'h00, smi_hi_q} :
                      (rd_idx == voltage_monitor_pkg::IDX_IRQ_LO) ? irq_lo_q :
                      (rd_idx == voltage_monitor_pkg::IDX_IRQ_HI) ? {5'h00, irq_hi_q} :
                      (rd_idx == voltage_monitor_pkg::IDX_VID) ? {vid_sel_q, 1'b0, vid_val} :
                      (rd_idx == voltage_monitor_pkg::IDX_CNVR) ? {2'h0, cnvr_q} :
                      (rd_idx == voltage_monitor_pkg::IDX_MCFG) ? mcfg_q :
                      (rd_idx == voltage_monitor_pkg::IDX_BANK) ? bank_q :
                      bank_ok ? bank_rd : 8'h00;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ref_default_a: assert property (@(posedge ref_clk_i) reset_i |=> !use_internal_ref_o)
    else $error("reference not external after reset");
  ref_share_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !$past(reset_i) |-> use_internal_ref_o == $past(iref_any))
    else $error("shared reference selection wrong");
  bank_reset_a: assert property (@(posedge ref_clk_i) reset_i |=> bank_q == 8'h00)
    else $error("bank select not zero after reset");
  bank_read_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ar_take && rd_map && rd_idx == voltage_monitor_pkg::IDX_BANK
    |=> s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(bank_q))
    else $error("bank select read wrong");
  w1c_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    hi_clr[0] && !hi_exceed_i[0] |=> !hi_q[0])
    else $error("write one did not clear flag");
  set_wins_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    lo_exceed_i[7] |=> sts_lo[7] ##0 lo_q[7])
    else $error("event lost or status not set");
  status_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    lo_q[9] && !lo_clr[9] |=> lo_q[9] && sts_hi[1])
    else $error("sticky flag dropped");
  mgmt_irq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !$past(reset_i) |-> mgmt_irq_o == $past(|(evt_status & smi_en)))
    else $error("management interrupt mismatch");
  host_irq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    |(evt_status & irq_en) |=> host_irq_o)
    else $error("host interrupt not raised");
  reserved_rd_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ar_take && (rd_idx > voltage_monitor_pkg::IDX_LLIM || !bank_ok && rd_idx >= voltage_monitor_pkg::IDX_CFGST)
    |=> s_axi_rdata_o == 32'h00000000)
    else $error("reserved location read nonzero");
  write_resp_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    aw_take && w_take && !aw_full_q && !w_full_q |=> ##1 s_axi_bvalid_o)
    else $error("write response late");
  // A clear that meets a new event must lose, or an alarm goes unseen
  clear_race_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    hi_exceed_i[5] && hi_clr[5] |=> hi_q[5])
    else $error("clear won over a new event");
  alarm_out_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !$past(reset_i) |-> alarm_o == $past(|(evt_status & alm_q)))
    else $error("alarm output mismatch");
  route_reset_a: assert property (@(posedge ref_clk_i)
    reset_i |=> smi_lo_q == voltage_monitor_pkg::RST_BYTE && smi_hi_q == 3'h0)
    else $error("routing enables not cleared by reset");
  vid_split_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    we_vid |=> vid_sel_q == $past(wdata_q[7:6]))
    else $error("voltage ident select not stored");
  cfg_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ch_we[5] && wr_idx == voltage_monitor_pkg::IDX_CFGST
    |=> chan_enable_o[5] == $past(wdata_q[voltage_monitor_pkg::CFG_EN]))
    else $error("channel enable not stored");
  readout_cap_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    readout_valid_i[2] |=> rdv_q[2] == $past(readout_i[23:16]))
    else $error("readout not captured");

  write_done_c: cover property (@(posedge ref_clk_i) s_axi_bvalid_o && s_axi_bready_i);
  read_done_c: cover property (@(posedge ref_clk_i) s_axi_rvalid_o && s_axi_rready_i);
  mgmt_rise_c: cover property (@(posedge ref_clk_i) $rose(mgmt_irq_o));
  clear_c: cover property (@(posedge ref_clk_i) hi_clr[0] && hi_q[0]);
  race_c: cover property (@(posedge ref_clk_i) hi_exceed_i[5] && hi_clr[5]);
endmodule

// file: dv/tb_voltage_monitor_banked_regs.sv
// Self-checking bench for the voltage monitor register bank
module tb_voltage_monitor_banked_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, mgmt_irq, host_irq, use_iref, alarm, standby;
  logic [5:0] conv_rate;
  logic [10:0] chan_en;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd_data;
  logic [10:0] hi_ex = 11'h0, lo_ex = 11'h0, rd_vld = 11'h0, exp_sts;
  logic [87:0] readout = 88'h0, high_lim, low_lim;
  logic [4:0] vid0 = 5'h15, vid1 = 5'h0a;
  logic tms_iref = 1'b0;
  logic [7:0] rst_exp [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h15, 8'h00,
                               8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  int n_fail = 0, checked = 0, fb;

  voltage_monitor_banked_regs voltage_monitor_banked_regs_i (
    .ref_clk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .hi_exceed_i(hi_ex), .lo_exceed_i(lo_ex), .readout_i(readout), .readout_valid_i(rd_vld),
    .vid_cpu0_i(vid0), .vid_cpu1_i(vid1), .tms_int_ref_i(tms_iref),
    .mgmt_irq_o(mgmt_irq), .host_irq_o(host_irq), .alarm_o(alarm), .use_internal_ref_o(use_iref),
    .standby_o(standby), .conv_rate_o(conv_rate), .chan_enable_o(chan_en), .high_limit_o(high_lim),
    .low_limit_o(low_lim)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  // -------------------------------------------------------------------------
  // Bus tasks and checks
  // -------------------------------------------------------------------------
  function automatic logic [7:0] a(input logic [3:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic timed_out();
    n_fail++;
    $display("Error bus wait timed out");
    conclude();
  endtask

  task automatic check(input string name, input logic [87:0] seen, input logic [87:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Write data is offered with strobe bit 0 unless strb is cleared
  task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic strb = 1'b1);
    int n;
    bit aw_done, w_done;
    n = 0;
    aw_done = 0;
    w_done = 0;
    awaddr <= addr;
    wdata <= {24'h0, data};
    wstrb <= {3'h0, strb};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (++n > 100) timed_out();
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      if (++n > 200) timed_out();
    end while (bvalid !== 1'b1);
    // Response ready stays high between writes, never dropped and raised in one step
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] addr);
    int n;
    n = 0;
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (++n > 100) timed_out();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      if (++n > 200) timed_out();
    end while (rvalid !== 1'b1);
    rd_data = rdata;
    resp = rresp;
  endtask

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(3);
    for (int i = 0; i < 16; i++) begin
      rd(a(4'(i)));
      check("reset value", rd_data, {24'h0, rst_exp[i]});
    end
    check("use_internal_ref", use_iref, 1'b0);
    check("high limits", high_lim, {11{8'hff}});
    check("mgmt_irq reset", mgmt_irq, 1'b0);
    // Bank switching: limits land in the selected channel only
    wr(a(voltage_monitor_pkg::IDX_BANK), 8'h03);
    wr(a(voltage_monitor_pkg::IDX_HLIM), 8'h5a);
    wr(a(voltage_monitor_pkg::IDX_BANK), 8'h04);
    wr(a(voltage_monitor_pkg::IDX_LLIM), 8'h33);
    wr(a(voltage_monitor_pkg::IDX_HLIM), 8'h66, 1'b0);
    rd(a(voltage_monitor_pkg::IDX_BANK));
    check("bank select", rd_data, 32'h4);
    check("high limit ch3", high_lim[31:24], 8'h5a);
    check("high limit ch4 no strobe", high_lim[39:32], 8'hff);
    check("low limit ch4", low_lim[39:32], 8'h33);
    wr(a(voltage_monitor_pkg::IDX_BANK), 8'h03);
    rd(a(voltage_monitor_pkg::IDX_HLIM));
    check("readback ch3", rd_data, 32'h5a);
    // Bank beyond the implemented ten
    wr(a(voltage_monitor_pkg::IDX_BANK), 8'h0a);
    wr(a(voltage_monitor_pkg::IDX_HLIM), 8'h11);
    check("bank10 resp", resp, voltage_monitor_pkg::RESP_OKAY);
    rd(a(voltage_monitor_pkg::IDX_HLIM));
    check("bank10 read", rd_data, 32'h0);
    check("bank10 no effect", high_lim, {{7{8'hff}}, 8'h5a, {3{8'hff}}});
    // Outside the window and reserved offsets
    wr(8'h40, 8'hff);
    check("decerr write", resp, voltage_monitor_pkg::RESP_DECERR);
    rd(8'h40);
    check("decerr read", {resp, rd_data}, {voltage_monitor_pkg::RESP_DECERR, 32'h0});
    wr(a(4'he), 8'hff);
    rd(a(4'he));
    check("reserved offset", rd_data, 32'h0);
    // Readout capture is read-only
    readout <= 88'h9c << 16;
    rd_vld <= 11'h004;
    tick(1);
    rd_vld <= 11'h000;
    wr(a(voltage_monitor_pkg::IDX_BANK), 8'h02);
    wr(a(voltage_monitor_pkg::IDX_READ), 8'h01);
    rd(a(voltage_monitor_pkg::IDX_READ));
    check("readout ch2", rd_data, 32'h9c);
    // Split access: select is written, pin value is read
    wr(a(voltage_monitor_pkg::IDX_VID), 8'h5f);
    rd(a(voltage_monitor_pkg::IDX_VID));
    check("vid split", rd_data, {24'h0, 3'b010, vid1});
    // Event flags per banked channel, alternating high and low limits
    for (int ch = 0; ch < 10; ch++) begin
      fb = (ch % 2) ? 3 : 2;
      if (ch % 2) lo_ex <= 11'h1 << ch;
      else hi_ex <= 11'h1 << ch;
      tick(1);
      hi_ex <= 11'h0;
      lo_ex <= 11'h0;
      exp_sts = 11'h1 << ch;
      rd(a(voltage_monitor_pkg::IDX_STS_LO));
      check("status lo", rd_data, {24'h0, exp_sts[7:0]});
      rd(a(voltage_monitor_pkg::IDX_STS_HI));
      check("status hi", rd_data, {29'h0, exp_sts[10:8]});
      wr(a(voltage_monitor_pkg::IDX_BANK), 8'(ch));
      wr(a(voltage_monitor_pkg::IDX_CFGST), 8'h00);
      rd(a(voltage_monitor_pkg::IDX_CFGST));
      check("flag kept", rd_data, 32'h1 << fb);
      wr(a(voltage_monitor_pkg::IDX_CFGST), 8'h1 << fb);
      rd(a(voltage_monitor_pkg::IDX_CFGST));
      check("flag cleared", rd_data, 32'h0);
    end
    // Routing of a channel 0 event
    hi_ex <= 11'h001;
    tick(1);
    hi_ex <= 11'h000;
    wr(a(voltage_monitor_pkg::IDX_SMI_LO), 8'h80);
    tick(2);
    check("mgmt other bit", mgmt_irq, 1'b0);
    wr(a(voltage_monitor_pkg::IDX_SMI_LO), 8'h01);
    wr(a(voltage_monitor_pkg::IDX_IRQ_LO), 8'h01);
    tick(2);
    check("mgmt matched", mgmt_irq, 1'b1);
    check("host matched", host_irq, 1'b1);
    wr(a(voltage_monitor_pkg::IDX_BANK), 8'h00);
    wr(a(voltage_monitor_pkg::IDX_CFGST), 8'h04);
    tick(2);
    check("mgmt after clear", mgmt_irq, 1'b0);
    // Channel 10 on the upper registers, reserved bits dropped
    wr(a(voltage_monitor_pkg::IDX_SMI_HI), 8'hff);
    rd(a(voltage_monitor_pkg::IDX_SMI_HI));
    check("smi hi reserved", rd_data, 32'h7);
    wr(a(voltage_monitor_pkg::IDX_SMI_HI), 8'h03);
    lo_ex <= 11'h400;
    tick(1);
    lo_ex <= 11'h000;
    tick(2);
    check("mgmt ch10 masked", mgmt_irq, 1'b0);
    wr(a(voltage_monitor_pkg::IDX_IRQ_HI), 8'h04);
    rd(a(voltage_monitor_pkg::IDX_STS_HI));
    check("status ch10", rd_data, 32'h4);
    check("host ch10", host_irq, 1'b1);
    // Shared reference selection
    tms_iref <= 1'b1;
    tick(2);
    check("iref from temp unit", use_iref, 1'b1);
    tms_iref <= 1'b0;
    wr(a(voltage_monitor_pkg::IDX_MCFG), 8'h02);
    tick(2);
    check("iref from config", use_iref, 1'b1);
    wr(a(voltage_monitor_pkg::IDX_MCFG), 8'h00);
    tick(2);
    check("iref off", use_iref, 1'b0);
    // Channel enable and alarm output; an event held over a clear keeps the flag
    wr(a(voltage_monitor_pkg::IDX_BANK), 8'h05);
    wr(a(voltage_monitor_pkg::IDX_CFGST), 8'h03);
    tick(2);
    check("chan enable", chan_en, 11'h020);
    check("alarm idle", alarm, 1'b0);
    hi_ex <= 11'h020;
    wr(a(voltage_monitor_pkg::IDX_CFGST), 8'h07);
    hi_ex <= 11'h000;
    rd(a(voltage_monitor_pkg::IDX_CFGST));
    check("set beats clear", rd_data, 32'h7);
    check("alarm out", alarm, 1'b1);
    wr(a(voltage_monitor_pkg::IDX_CFGST), 8'h04);
    tick(2);
    check("alarm cleared", alarm, 1'b0);
    // Common settings, reserved rate bits and the reserved ident select
    wr(a(voltage_monitor_pkg::IDX_MCFG), 8'h01);
    wr(a(voltage_monitor_pkg::IDX_CNVR), 8'hff);
    rd(a(voltage_monitor_pkg::IDX_CNVR));
    check("conv rate read", rd_data, 32'h3f);
    check("conv rate out", conv_rate, 6'h3f);
    check("standby out", standby, 1'b1);
    wr(a(voltage_monitor_pkg::IDX_VID), 8'h80);
    rd(a(voltage_monitor_pkg::IDX_VID));
    check("vid reserved select", rd_data, 32'h80);
    // Second reset in mid-run
    wr(a(voltage_monitor_pkg::IDX_MCFG), 8'h02);
    wr(a(voltage_monitor_pkg::IDX_BANK), 8'h07);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(3);
    check("iref after reset", use_iref, 1'b0);
    rd(a(voltage_monitor_pkg::IDX_BANK));
    check("bank after reset", rd_data, 32'h0);
    rd(a(voltage_monitor_pkg::IDX_STS_HI));
    check("status after reset", rd_data, 32'h0);
    conclude();
  end
endmodule
